// ---- hdl/sau_map.svh ----
// widths, field positions, reset values and counts of the subtractive adder unit
`ifndef SAU_MAP_SVH
`define SAU_MAP_SVH

// ============================================================
// word layout
`define SAU_WIDTH       48
`define SAU_MSB         47
`define SAU_EXP_HI      47
`define SAU_EXP_LO      36
`define SAU_EXP_W       12
`define SAU_MANT_HI     35

// ============================================================
// step counter
`define SAU_STEP_W      7
`define SAU_STEP_MSB    6

// ============================================================
// reset values
`define SAU_WORD_RST    48'h0000_0000_0000
`define SAU_STEP_RST    7'h00
`define SAU_STEP_ONE    7'h01

`endif

// ---- hdl/sau_pkg.sv ----
// types of the subtractive adder unit
package sau_pkg;
`include "sau_map.svh"

    typedef logic [`SAU_MSB:0]      sau_word_t;
    typedef logic [`SAU_STEP_MSB:0] sau_step_t;

    typedef enum logic [3:0] {
        SAU_NOP        = 4'h0,
        SAU_HUB_LOAD   = 4'h1,
        SAU_HUB_UP2LO  = 4'h2,
        SAU_HUB_LO2UP  = 4'h3,
        SAU_HUB_CMPL   = 4'h4,
        SAU_ACC_CLR    = 4'h5,
        SAU_ACC_ADD    = 4'h6,
        SAU_ACC_TO_HUB = 4'h7,
        SAU_PART_SET   = 4'h8,
        SAU_PART_CLR   = 4'h9,
        SAU_STEP_LOAD  = 4'hA,
        SAU_MUL        = 4'hB,
        SAU_DIV        = 4'hC,
        SAU_LOG_PROD   = 4'hD,
        SAU_FP_PACK    = 4'hE,
        SAU_FP_UNPACK  = 4'hF
    } sau_op_t;

    typedef enum logic [1:0] {
        SAU_IDLE  = 2'b00,
        SAU_ADD   = 2'b01,
        SAU_SHIFT = 2'b10,
        SAU_COPY  = 2'b11
    } sau_state_t;

    typedef struct packed {
        logic      valid;
        sau_op_t   op;
        sau_word_t word;
    } sau_cmd_t;

    typedef struct packed {
        sau_word_t hub;
        sau_word_t acc;
        sau_step_t steps;
        logic      partial;
    } sau_view_t;

endpackage

// ---- hdl/sau_unit.sv ----
// one's complement subtractive adder with double-rank hub and step engine
//
// Notes on behaviour
// - hub register is 48 bits, each bit held in an upper and lower rank.
// - hub ranks copy only on explicit upper-to-lower or lower-to-upper commands.
// - every data word entering the unit passes through the hub register; step-load words go straight to the step counter; VIEW_O shows the accumulator directly.
// - hub supports complement, logical product, float pack/unpack and arithmetic feed.
// - multiply and divide repeat add or subtract, then shift.
// - step counter drops by one per step; operation ends at zero.
// - one's complement inverts every bit of the word.
// - hub is added by subtracting its complement from the accumulator.
// - zero subtrahend keeps minuend bit; one inverts it, borrowing when minuend zero.
// - logical difference inverts accumulator bits where hub bit is zero.
// - borrow from stage n generated when both bits n-1 were zero.
// - add command gates each stage toggle; afterwards the accumulator holds the sum.
// - toggle when hub bit zero without borrow, or one with borrow.
// - borrow through a zero stage propagates upward until a one stage.
// - borrow out of bit 47 wraps end-around into bit 0.
// - partial-add flag disables borrows; add then only toggles by hub bits.
// - accumulator lower rank mirrors upper rank unless separately needed.
`timescale 1ns/1ns
`include "sau_map.svh"

module sau_unit
    import sau_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        SRST_I,
    input  wire sau_pkg::sau_cmd_t CMD_I,
    output logic             CMD_READY_O,
    output sau_pkg::sau_word_t HUB_O,
    output sau_pkg::sau_view_t VIEW_O,
    output logic             BUSY_O,
    output logic             DONE_O
);
    import sau_pkg::*;

    // ============================================================
    // borrow arithmetic

    // ripple borrow chain for a minus complement of x, with borrow into bit 0
    function automatic logic [`SAU_MSB+1:0] borrow_chain(
        input sau_word_t a,
        input sau_word_t x,
        input logic      bin
    );
        sau_word_t ld;
        sau_word_t b;
        logic      c;
        integer    i;
        ld = a ^ ~x;
        c  = bin;
        for (i = 0; i < `SAU_WIDTH; i = i + 1) begin
            b[i] = c;
            // generate when both zero, else pass through a zero difference
            c = (~a[i] & ~x[i]) | (~ld[i] & c);
        end
        return {c, b};
    endfunction

    // single toggle command: accumulator minus complement of hub
    function automatic sau_word_t sub_add(
        input sau_word_t a,
        input sau_word_t x,
        input logic      part
    );
        logic [`SAU_MSB+1:0] first;
        logic [`SAU_MSB+1:0] second;
        sau_word_t           t;
        first  = borrow_chain(a, x, 1'b0);
        // end-around: the top borrow is taken from the lowest stage
        second = borrow_chain(a, x, first[`SAU_MSB+1]);
        if (part) begin
            t = x;
        end else begin
            t = ~(x ^ second[`SAU_MSB:0]);
        end
        return a ^ t;
    endfunction

    // one shift per step: right keeps the sign, left wraps the top bit round
    function automatic sau_word_t step_shift(
        input sau_word_t w,
        input logic      left
    );
        sau_word_t s;
        if (left) begin
            s = {w[`SAU_MSB-1:0], w[`SAU_MSB]};
        end else begin
            s = {w[`SAU_MSB], w[`SAU_MSB:1]};
        end
        return s;
    endfunction

    // ============================================================
    // state

    sau_word_t  hub_upper_rank_q;
    sau_word_t  hub_upper_rank_d;
    sau_word_t  hub_lower_rank_q;
    sau_word_t  hub_lower_rank_d;
    sau_word_t  sum_upper_rank_q;
    sau_word_t  sum_upper_rank_d;
    sau_word_t  sum_lower_rank_q;
    sau_word_t  sum_lower_rank_d;
    sau_step_t  steps_q;
    sau_step_t  steps_d;
    logic       partial_q;
    logic       partial_d;
    logic       divide_q;
    logic       divide_d;
    logic       done_q;
    logic       done_d;
    sau_state_t state_q;
    sau_state_t state_d;
    logic       take;
    sau_word_t  added;

    assign take        = CMD_I.valid && (state_q == SAU_IDLE);
    assign CMD_READY_O = (state_q == SAU_IDLE);
    // adder senses lower ranks and writes the upper accumulator rank
    assign added       = sub_add(sum_lower_rank_q, hub_lower_rank_q, partial_q);

    // ============================================================
    // next values

    // hub group: ranks move only on their own commands
    always_comb begin
        hub_upper_rank_d = hub_upper_rank_q;
        hub_lower_rank_d = hub_lower_rank_q;
        if (take) begin
            case (CMD_I.op)
                SAU_HUB_LOAD: begin
                    // inbound words land in the hub only
                    hub_upper_rank_d = CMD_I.word;
                end
                SAU_HUB_UP2LO: begin
                    hub_lower_rank_d = hub_upper_rank_q;
                end
                SAU_HUB_LO2UP: begin
                    hub_upper_rank_d = hub_lower_rank_q;
                end
                SAU_HUB_CMPL: begin
                    hub_upper_rank_d = ~hub_lower_rank_q;
                end
                SAU_ACC_TO_HUB: begin
                    // outbound results leave through the hub
                    hub_upper_rank_d = sum_lower_rank_q;
                end
                SAU_LOG_PROD: begin
                    hub_upper_rank_d = hub_lower_rank_q & CMD_I.word;
                end
                SAU_FP_PACK: begin
                    hub_upper_rank_d = {CMD_I.word[`SAU_EXP_W-1:0],
                                        hub_lower_rank_q[`SAU_MANT_HI:0]};
                end
                SAU_FP_UNPACK: begin
                    hub_upper_rank_d = {{`SAU_EXP_W{hub_lower_rank_q[`SAU_MANT_HI]}},
                                        hub_lower_rank_q[`SAU_MANT_HI:0]};
                end
                default: begin
                end
            endcase
        end
    end

    // accumulator group: adder result, step copy and the shift in the lower rank
    always_comb begin
        sum_upper_rank_d = sum_upper_rank_q;
        case (state_q)
            SAU_IDLE: begin
                if (take && (CMD_I.op == SAU_ACC_CLR)) begin
                    sum_upper_rank_d = `SAU_WORD_RST;
                end else if (take && (CMD_I.op == SAU_ACC_ADD)) begin
                    sum_upper_rank_d = added;
                end
            end
            SAU_ADD: begin
                // divide subtracts: hub is expected to hold the complement
                sum_upper_rank_d = added;
            end
            SAU_COPY: begin
                // upper rank takes the shifted word back
                sum_upper_rank_d = sum_lower_rank_q;
            end
            default: begin
            end
        endcase
        // lower rank mirrors, except while it holds the shift
        sum_lower_rank_d = sum_upper_rank_d;
        if (state_q == SAU_SHIFT) begin
            sum_lower_rank_d = step_shift(sum_upper_rank_q, divide_q);
        end
    end

    // sequence group: partial flag, step counter and the step engine
    always_comb begin
        steps_d   = steps_q;
        partial_d = partial_q;
        divide_d  = divide_q;
        done_d    = 1'b0;
        state_d   = state_q;
        case (state_q)
            SAU_IDLE: begin
                if (take) begin
                    case (CMD_I.op)
                        SAU_PART_SET: begin
                            partial_d = 1'b1;
                        end
                        SAU_PART_CLR: begin
                            partial_d = 1'b0;
                        end
                        SAU_STEP_LOAD: begin
                            steps_d = CMD_I.word[`SAU_STEP_MSB:0];
                        end
                        SAU_MUL, SAU_DIV: begin
                            divide_d = (CMD_I.op == SAU_DIV);
                            // zero count means nothing to repeat
                            if (steps_q == `SAU_STEP_RST) begin
                                done_d = 1'b1;
                            end else begin
                                state_d = SAU_ADD;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SAU_ADD: begin
                state_d = SAU_SHIFT;
            end
            SAU_SHIFT: begin
                // lower rank takes the shifted word this phase
                state_d = SAU_COPY;
            end
            SAU_COPY: begin
                steps_d = steps_q - `SAU_STEP_ONE;
                if (steps_q == `SAU_STEP_ONE) begin
                    done_d  = 1'b1;
                    state_d = SAU_IDLE;
                end else begin
                    state_d = SAU_ADD;
                end
            end
            default: begin
                state_d = SAU_IDLE;
            end
        endcase
    end

    // ============================================================
    // registers

    // hub ranks
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            hub_upper_rank_q <= `SAU_WORD_RST;
            hub_lower_rank_q <= `SAU_WORD_RST;
        end else begin
            hub_upper_rank_q <= hub_upper_rank_d;
            hub_lower_rank_q <= hub_lower_rank_d;
        end
    end

    // accumulator ranks
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            sum_upper_rank_q <= `SAU_WORD_RST;
            sum_lower_rank_q <= `SAU_WORD_RST;
        end else begin
            sum_upper_rank_q <= sum_upper_rank_d;
            sum_lower_rank_q <= sum_lower_rank_d;
        end
    end

    // sequence state
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            steps_q   <= `SAU_STEP_RST;
            partial_q <= 1'b0;
            divide_q  <= 1'b0;
            done_q    <= 1'b0;
            state_q   <= SAU_IDLE;
        end else begin
            steps_q   <= steps_d;
            partial_q <= partial_d;
            divide_q  <= divide_d;
            done_q    <= done_d;
            state_q   <= state_d;
        end
    end

    // ============================================================
    // outputs

    // HUB_O carries the hub lower rank; VIEW_O shows hub upper rank, accumulator, steps and partial flag
    assign HUB_O         = hub_lower_rank_q;
    assign VIEW_O.hub    = hub_upper_rank_q;
    assign VIEW_O.acc    = sum_lower_rank_q;
    assign VIEW_O.steps  = steps_q;
    assign VIEW_O.partial = partial_q;
    assign BUSY_O        = (state_q != SAU_IDLE);
    assign DONE_O        = done_q;

endmodule

// ---- verif/sau_seq_model.sv ----
// sequencer model feeding commands to the subtractive adder unit
`timescale 1ns/1ns

module sau_seq_model
    import sau_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ready_i,
    input  wire logic              slow_i,
    output sau_pkg::sau_cmd_t      cmd_o,
    output logic                   took_o,
    output sau_pkg::sau_op_t       took_op_o
);
    // ======
    // command issue
    sau_cmd_t pend[$];
    logic     can_move;
    // a held command may only move on once it has been taken
    assign can_move = !cmd_o.valid || ready_i;
    initial begin
        cmd_o = '0;
        took_o = 1'b0;
        took_op_o = SAU_NOP;
    end
    always @(posedge clk_i) begin
        took_o <= #1 !rst_i && cmd_o.valid && ready_i;
        took_op_o <= #1 cmd_o.op;
        if (rst_i || (can_move && (pend.size() == 0 || (slow_i && cmd_o.valid)))) begin
            // released word toggles so a stale copy never looks valid
            cmd_o <= #1 '{1'b0, cmd_o.op, ~cmd_o.word};
        end else if (can_move) begin
            cmd_o <= #1 pend.pop_front();
        end
    end
endmodule

// ---- verif/sau_unit_sva.sv ----
// port assertions for the subtractive adder unit
`timescale 1ns/1ns

module sau_unit_sva
    import sau_pkg::*;
(
    input wire logic               CORE_CLK_I,
    input wire logic               SRST_I,
    input wire sau_pkg::sau_cmd_t  CMD_I,
    input wire logic               CMD_READY_O,
    input wire sau_pkg::sau_word_t HUB_O,
    input wire sau_pkg::sau_view_t VIEW_O,
    input wire logic               BUSY_O,
    input wire logic               DONE_O
);
    // ======
    // helpers
    logic take;
    assign take = CMD_I.valid && CMD_READY_O;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    // borrow out of the top stage comes back in at bit 0
    function automatic sau_word_t oc_sum(input sau_word_t a, input sau_word_t x);
        return (a >= ~x) ? a - ~x : a - ~x - 48'h0000_0000_0001;
    endfunction

    // ======
    // assertions
    hub_hold_a: assert property (
        !(take && CMD_I.op == SAU_HUB_UP2LO) |=> $stable(HUB_O)) else $error("hub lower moved");
    hub_copy_a: assert property (
        take && CMD_I.op == SAU_HUB_UP2LO |=> HUB_O == $past(VIEW_O.hub)) else $error("no copy");
    cmpl_bits_a: assert property (
        take && CMD_I.op == SAU_HUB_CMPL |=> VIEW_O.hub == ~$past(HUB_O)) else $error("bad cmpl");
    acc_hub_a: assert property (
        take && CMD_I.op == SAU_ACC_TO_HUB |=> VIEW_O.hub == $past(VIEW_O.acc))
        else $error("acc not sent to hub");
    part_add_a: assert property (
        take && CMD_I.op == SAU_ACC_ADD && VIEW_O.partial
        |=> VIEW_O.acc == ($past(VIEW_O.acc) ^ $past(HUB_O))) else $error("bad partial add");
    full_add_a: assert property (
        take && CMD_I.op == SAU_ACC_ADD && !VIEW_O.partial
        |=> VIEW_O.acc == oc_sum($past(VIEW_O.acc), $past(HUB_O))) else $error("bad sum");
    step_dec_a: assert property (
        $past(BUSY_O) && $changed(VIEW_O.steps) |-> VIEW_O.steps == $past(VIEW_O.steps) - 7'h01)
        else $error("step count jump");
    mul_len_a: assert property (
        take && CMD_I.op == SAU_MUL && VIEW_O.steps == 7'h01
        |=> BUSY_O [*3] ##1 (DONE_O && !BUSY_O)) else $error("bad step length");
    busy_refuse_a: assert property (
        BUSY_O && CMD_I.valid |=> $stable(HUB_O) && $stable(VIEW_O.hub) && $stable(VIEW_O.partial))
        else $error("command taken while busy");
    zero_step_a: assert property (
        take && CMD_I.op inside {SAU_MUL, SAU_DIV} && VIEW_O.steps == 7'h00
        |=> DONE_O && $stable(VIEW_O.acc)) else $error("zero count not immediate");
endmodule

bind sau_unit sau_unit_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .CMD_I(CMD_I),
    .CMD_READY_O(CMD_READY_O), .HUB_O(HUB_O), .VIEW_O(VIEW_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));

// ---- verif/sau_unit_tb.sv ----
// self-checking bench of the subtractive adder unit
`timescale 1ns/1ns

module sau_unit_tb;
    import sau_pkg::*;
    logic      core_clk = 1'b0;
    logic      srst = 1'b1;
    logic      slow = 1'b0;
    sau_cmd_t  cmd;
    logic      ready, busy, done, took;
    sau_op_t   took_op;
    sau_word_t hub_o, m_up, m_lo, m_acc;
    sau_view_t view;
    sau_step_t m_st;
    logic      m_pt;
    logic [47:0]  lfsr = 48'h0000_0000_0029;
    logic [151:0] expq[$];
    int        error_cnt = 0;
    int        checks_done = 0;
    int        cyc = 0;

    initial forever #20 core_clk = ~core_clk;
    sau_unit u_dut (.CORE_CLK_I(core_clk), .SRST_I(srst), .CMD_I(cmd), .CMD_READY_O(ready),
        .HUB_O(hub_o), .VIEW_O(view), .BUSY_O(busy), .DONE_O(done));
    sau_seq_model u_seq (.clk_i(core_clk), .rst_i(srst), .ready_i(ready), .slow_i(slow),
        .cmd_o(cmd), .took_o(took), .took_op_o(took_op));

    // ======
    // reference model
    function automatic logic [47:0] nxt(input logic [47:0] s);
        return {s[46:0], s[47] ^ s[46] ^ s[20] ^ s[19]};
    endfunction
    function automatic sau_word_t ref_sum(input sau_word_t a, input sau_word_t x);
        return (a >= ~x) ? a - ~x : a - ~x - 48'h0000_0000_0001;
    endfunction
    task automatic issue(input sau_op_t op, input sau_word_t w);
        case (op)
            SAU_HUB_LOAD:   m_up = w;
            SAU_HUB_UP2LO:  m_lo = m_up;
            SAU_HUB_LO2UP:  m_up = m_lo;
            SAU_HUB_CMPL:   m_up = ~m_lo;
            SAU_ACC_CLR:    m_acc = '0;
            SAU_ACC_ADD:    m_acc = m_pt ? m_acc ^ m_lo : ref_sum(m_acc, m_lo);
            SAU_ACC_TO_HUB: m_up = m_acc;
            SAU_PART_SET:   m_pt = 1'b1;
            SAU_PART_CLR:   m_pt = 1'b0;
            SAU_STEP_LOAD:  m_st = w[6:0];
            SAU_LOG_PROD:   m_up = m_lo & w;
            SAU_FP_PACK:    m_up = {w[11:0], m_lo[35:0]};
            SAU_FP_UNPACK:  m_up = {{12{m_lo[35]}}, m_lo[35:0]};
            SAU_MUL, SAU_DIV: begin
                while (m_st != 7'h00) begin
                    m_acc = ref_sum(m_acc, m_lo);
                    m_acc = (op == SAU_MUL) ? {m_acc[47], m_acc[47:1]} : {m_acc[46:0], m_acc[47]};
                    m_st  = m_st - 7'h01;
                end
            end
            default: ;
        endcase
        expq.push_back({m_lo, m_up, m_acc, m_st, m_pt});
        u_seq.pend.push_back({1'b1, op, w});
    endtask
    task automatic add_pair(input sau_word_t a, input sau_word_t x);
        issue(SAU_ACC_CLR, '0);
        issue(SAU_HUB_LOAD, a);
        issue(SAU_HUB_UP2LO, '0);
        issue(SAU_ACC_ADD, '0);
        issue(SAU_HUB_LOAD, x);
        issue(SAU_HUB_UP2LO, '0);
        issue(SAU_ACC_ADD, '0);
    endtask
    task automatic wait_idle();
        while (u_seq.pend.size() != 0 || expq.size() != 0) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ======
    // result watcher and hang guard
    always @(negedge core_clk) begin
        if (!srst && ((took && !(took_op inside {SAU_MUL, SAU_DIV})) || done === 1'b1)) begin
            checks_done++;
            if (expq.size() == 0 || {hub_o, view} !== expq[0]) begin
                error_cnt++;
                $display("BAD %0t unit state differs from model", $time);
            end
            if (expq.size() != 0) void'(expq.pop_front());
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ======
    // main sequence
    initial begin
        {m_up, m_lo, m_acc, m_st, m_pt} = '0;
        repeat (12) @(posedge core_clk);
        #1 srst = 1'b0;
        checks_done++;
        if ({hub_o, view, busy, done} !== '0 || ready !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t outputs after reset", $time);
        end
        add_pair(48'h0000_0000_0005, 48'h0000_0000_0003);
        add_pair(48'h0000_0000_0005, 48'hFFFF_FFFF_FFFA);
        add_pair(48'h7FFF_FFFF_FFFF, 48'h0000_0000_0001);
        add_pair(48'hFFFF_FFFF_FFFF, 48'hFFFF_FFFF_FFFF);
        issue(SAU_PART_SET, '0);
        issue(SAU_ACC_ADD, '0);
        issue(SAU_PART_CLR, '0);
        issue(SAU_STEP_LOAD, 48'h0000_0000_0001);
        issue(SAU_MUL, '0);
        issue(SAU_STEP_LOAD, 48'h0000_0000_0001);
        issue(SAU_DIV, '0);
        issue(SAU_MUL, '0);
        wait_idle();
        for (int r = 0; r < 10; r++) begin
            slow = lfsr[0];
            for (int op = 0; op < 16; op++) begin
                lfsr = nxt(lfsr);
                issue(sau_op_t'(op), lfsr);
            end
            wait_idle();
        end
        give_verdict();
    end
endmodule
